// File: core/tcf_pkg.sv
// Purpose: Shared constants and types for the tape channel decoder
// Assumes: 26-bit words, bit 0 unused, bits 25..1 as printed
// Notes:   Indicator bit positions equal the indicator codes
`default_nettype none
package tcf_pkg;
  localparam int BUS_AW = 4;
  localparam int DW = 32;
  localparam int WW = 26;
  localparam logic [3:0] REG_FS = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_INFO = 4'hc;
  localparam int FS_UNIT_LO = 21;
  localparam int UNIT_W = 4;
  localparam int FS_FUNC_LO = 17;
  localparam int FUNC_W = 4;
  localparam int FS_INT_BIT = 16;
  localparam int FS_ADDR_LO = 1;
  localparam int ADDR_W = 15;
  localparam int DESC_STOP_BIT = 25;
  localparam int DESC_CNT_LO = 16;
  localparam int CNT_W = 9;
  localparam int ST_W = 3;
  localparam int INFO_USED = ADDR_W + 2 + ST_W;
  localparam int CTRL_RDCH = 0;
  localparam int STAT_W = 8;
  localparam int IND_OK = 2;
  localparam int IND_ERRA = 3;
  localparam int IND_BUSY = 4;
  localparam int IND_HARD = 5;
  localparam int IND_EOT = 6;
  localparam int IND_FAULT = 7;
  localparam logic [ADDR_W-1:0] STBY_ADDR = 15'h0010;
  localparam logic [ADDR_W-1:0] ADDR_INC = 15'h0001;
  localparam logic [ADDR_W-1:0] ADDR_DEC = 15'h7fff;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
  localparam int SYNC_W = WW + 10;

  typedef enum logic [3:0] {
    FN_COLLECT_WRITE = 4'h1,
    FN_OVERLAY_WRITE = 4'h5,
    FN_FWD_SPREAD_READ = 4'h0,
    FN_BACK_SPREAD_READ = 4'h2,
    FN_FWD_BLOCK_READ = 4'h4,
    FN_BACK_BLOCK_READ = 4'h6,
    FN_BACK_RECOVERY_BLOCK_READ = 4'he,
    FN_BACK_RECOVERY_SPREAD_READ = 4'ha,
    FN_FWD_RECOVERY_BLOCK_READ = 4'hc,
    FN_FWD_RECOVERY_SPREAD_READ = 4'h8,
    FN_REWIND = 4'h3,
    FN_REWIND_LOCKED = 4'h7,
    FN_LOAD_POINT_CHECK = 4'hf
  } tcf_func_e;

  typedef enum logic [2:0] {
    TC_NONE = 3'h0,
    TC_SKIP_FWD = 3'h1,
    TC_READ_FWD = 3'h2,
    TC_READ_BACK = 3'h3,
    TC_REWIND = 3'h4,
    TC_REWIND_LOCKED = 3'h5,
    TC_WRITE = 3'h6
  } tcf_tape_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_SKIP = 3'h2,
    ST_DESC = 3'h3,
    ST_XFER = 3'h4,
    ST_WAIT = 3'h5,
    ST_FINISH = 3'h6
  } tcf_state_e;
endpackage
`default_nettype wire

// File: core/tcf_dec_if.sv
// Purpose: Carrier between the channel and its function decoder
// Assumes: Purely combinational signals
// Notes:   None
`default_nettype none
interface tcf_dec_if;
  logic [3:0] func;
  logic valid;
  logic is_write;
  logic is_recov;
  logic is_scatter;
  logic is_back;
  logic is_rewind;
  logic is_locked;
  logic is_lpt;
  modport dec (input func, output valid, is_write, is_recov, is_scatter,
    is_back, is_rewind, is_locked, is_lpt);
  modport ctl (output func, input valid, is_write, is_recov, is_scatter,
    is_back, is_rewind, is_locked, is_lpt);
endinterface
`default_nettype wire

// File: core/tcf_decode.sv
// Purpose: Decodes the 4-bit function field into operation flags
// Assumes: Field taken from specifier bits 20..17
// Notes:   Unassigned patterns drop valid
`default_nettype none
module tcf_decode (
  tcf_dec_if.dec dec
);
  always_comb begin
    dec.valid = 1'b1;
    dec.is_write = 1'b0;
    dec.is_recov = 1'b0;
    dec.is_scatter = 1'b0;
    dec.is_back = 1'b0;
    dec.is_rewind = 1'b0;
    dec.is_locked = 1'b0;
    dec.is_lpt = 1'b0;
    case (dec.func)
      tcf_pkg::FN_COLLECT_WRITE, tcf_pkg::FN_OVERLAY_WRITE: dec.is_write = 1'b1;
      tcf_pkg::FN_FWD_SPREAD_READ: dec.is_scatter = 1'b1;
      tcf_pkg::FN_BACK_SPREAD_READ,
      tcf_pkg::FN_BACK_RECOVERY_SPREAD_READ: begin
        dec.is_scatter = 1'b1;
        dec.is_back = 1'b1;
      end
      tcf_pkg::FN_FWD_BLOCK_READ: dec.valid = 1'b1;
      tcf_pkg::FN_BACK_BLOCK_READ,
      tcf_pkg::FN_BACK_RECOVERY_BLOCK_READ: dec.is_back = 1'b1;
      tcf_pkg::FN_FWD_RECOVERY_BLOCK_READ: dec.is_recov = 1'b1;
      tcf_pkg::FN_FWD_RECOVERY_SPREAD_READ: begin
        dec.is_recov = 1'b1;
        dec.is_scatter = 1'b1;
      end
      tcf_pkg::FN_REWIND: dec.is_rewind = 1'b1;
      tcf_pkg::FN_REWIND_LOCKED: begin
        dec.is_rewind = 1'b1;
        dec.is_locked = 1'b1;
      end
      tcf_pkg::FN_LOAD_POINT_CHECK: dec.is_lpt = 1'b1;
      default: dec.valid = 1'b0;
    endcase
  end
endmodule // tcf_decode
`default_nettype wire

// File: core/tcf_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Multi-bit data held stable around its strobe toggle
// Notes:   First stage read only by second stage
`default_nettype none
module tcf_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule // tcf_sync
`default_nettype wire

// File: core/tcf_channel.sv
// Purpose: Function specifier decode and indicators, one tape channel
// Assumes: Memory answers reads with i_mem_valid, takes writes at once
// Notes:   Tape word and done events arrive as toggles on pins
// Overview of operation
// - Forward recovery block read: skip one, read ascending
// - Forward recovery spread read: skip one, use descriptors
// - Ordinary reads accepted again after recovery
// - Free rewind to load point, address ignored
// - Locked rewind holds unit until release
// - Load test: success if at point, else errors
// - Load test on busy unit: busy only
// - Load test on faulted unit: fault only
// - Decode 4-bit function field, thirteen codes
// - Six indicators at codes 2,7,4,6,3,5
// - No standby access after failed specifier
// - Errored channel frees unit, indicators kept
// - Read errors posted at end, write immediately
// - Success only with interrupt and no error
// - Success never with others except end warning
// - Fault on operator conditions, write on read
// - Busy on rewinding or other-channel use
// - Stop descriptor first: skip, still check
`default_nettype none
module tcf_channel (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [3:0] i_bus_addr,
  input wire logic [31:0] i_bus_wdata,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  output logic [31:0] o_bus_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [14:0] o_mem_addr,
  output logic [25:0] o_mem_wdata,
  input wire logic i_mem_valid,
  input wire logic [25:0] i_mem_rdata,
  input wire logic [25:0] i_tape_word,
  input wire logic i_tape_word_tgl,
  input wire logic i_tape_word_err,
  input wire logic i_tape_bad_spot,
  input wire logic i_tape_done_tgl,
  input wire logic i_tape_eot,
  input wire logic i_unit_busy,
  input wire logic i_unit_fault,
  input wire logic i_load_point,
  input wire logic i_other_chan_busy,
  input wire logic i_change_release,
  output logic o_tape_start,
  output logic [2:0] o_tape_cmd,
  output logic [3:0] o_unit_sel,
  output logic o_unit_hold,
  output logic o_unit_locked
);
  // ----------------------------------------------------------------
  // Pin synchronisers and events
  // ----------------------------------------------------------------
  logic [tcf_pkg::SYNC_W-1:0] pin_s;
  tcf_sync #(.W(tcf_pkg::SYNC_W)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_d({i_tape_word, i_tape_word_tgl, i_tape_word_err, i_tape_bad_spot,
      i_tape_done_tgl, i_tape_eot, i_unit_busy, i_unit_fault,
      i_load_point, i_other_chan_busy, i_change_release}),
    .o_q(pin_s)
  );
  wire logic [25:0] word_s = pin_s[tcf_pkg::SYNC_W-1 -: tcf_pkg::WW];
  wire logic wtgl_s = pin_s[9];
  wire logic werr_s = pin_s[8];
  wire logic bad_s = pin_s[7];
  wire logic dtgl_s = pin_s[6];
  wire logic eot_s = pin_s[5];
  wire logic ubusy_s = pin_s[4];
  wire logic ufault_s = pin_s[3];
  wire logic lp_s = pin_s[2];
  wire logic other_s = pin_s[1];
  wire logic rel_s = pin_s[0];

  logic wtgl_q, dtgl_q, eot_q;
  wire logic word_ev = wtgl_s ^ wtgl_q;
  wire logic done_ev = dtgl_s ^ dtgl_q;
  wire logic eot_rise = eot_s & ~eot_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tcf_pkg::tcf_state_e state_r, state_nxt;
  tcf_pkg::tcf_tape_e cmd_r, cmd_nxt;
  logic [25:0] fs_r, fs_nxt;
  logic ctrl_r, ctrl_nxt;
  logic [7:0] stat_r, stat_nxt, stat_set;
  logic [14:0] ptr_r, ptr_nxt, addr_r, addr_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic segment_descriptor_r, segment_descriptor_nxt, back_r, back_nxt, first_r, first_nxt;
  logic stop_r, stop_nxt, pend_r, pend_nxt;
  logic hard_r, hard_nxt, erra_r, erra_nxt;
  logic lock_r, lock_nxt, hold_r, hold_nxt, start_r, start_nxt;
  logic [3:0] lock_unit_r, lock_unit_nxt;
  logic req_r, req_nxt, we_r, we_nxt;
  logic [14:0] maddr_r, maddr_nxt;
  logic [25:0] mdata_r, mdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // Decode and bus selection
  // ----------------------------------------------------------------
  tcf_dec_if u_dif ();
  tcf_decode u_dec (.dec(u_dif));
  assign u_dif.func = fs_r[tcf_pkg::FS_FUNC_LO +: tcf_pkg::FUNC_W];

  wire logic [3:0] unit = fs_r[tcf_pkg::FS_UNIT_LO +: tcf_pkg::UNIT_W];
  wire logic [14:0] fs_addr = fs_r[tcf_pkg::FS_ADDR_LO +: tcf_pkg::ADDR_W];
  wire logic fs_int = fs_r[tcf_pkg::FS_INT_BIT];
  wire logic rd_chan = ctrl_r;
  wire logic locked_here = lock_r && (lock_unit_r == unit);
  wire logic [14:0] step = back_r ? tcf_pkg::ADDR_DEC : tcf_pkg::ADDR_INC;
  wire logic wr_fs = i_bus_wr && (i_bus_addr == tcf_pkg::REG_FS);
  wire logic wr_stat = i_bus_wr && (i_bus_addr == tcf_pkg::REG_STAT);
  wire logic wr_ctrl = i_bus_wr && (i_bus_addr == tcf_pkg::REG_CTRL);
  wire logic [7:0] stat_clr = wr_stat ? i_bus_wdata[7:0] : '0;
  wire logic desc_stop = i_mem_rdata[tcf_pkg::DESC_STOP_BIT];
  wire logic in_chk = state_r == tcf_pkg::ST_CHECK;
  wire logic chk_lpt = in_chk && u_dif.valid && u_dif.is_lpt;
  wire logic move_ok = !(ubusy_s || other_s || ufault_s || locked_here);
  wire logic chk_go = in_chk && u_dif.valid && move_ok &&
    !(u_dif.is_write && rd_chan) && !u_dif.is_lpt;
  wire logic pend_err = hard_r || erra_r;
  wire logic xfer_on = !stop_r && (!segment_descriptor_r || cnt_r != '0);
  wire logic [31:0] rd_mux =
    (i_bus_addr == tcf_pkg::REG_FS) ? {6'h00, fs_r} :
    (i_bus_addr == tcf_pkg::REG_STAT) ? {24'h000000, stat_r} :
    (i_bus_addr == tcf_pkg::REG_CTRL) ? {31'h00000000, ctrl_r} :
    (i_bus_addr == tcf_pkg::REG_INFO) ?
      {{(tcf_pkg::DW-tcf_pkg::INFO_USED){1'b0}}, addr_r, hold_r,
       lock_r, state_r} : '0;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    fs_nxt = fs_r;
    ptr_nxt = ptr_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    segment_descriptor_nxt = segment_descriptor_r;
    back_nxt = back_r;
    first_nxt = first_r;
    stop_nxt = stop_r;
    pend_nxt = pend_r;
    hard_nxt = hard_r;
    erra_nxt = erra_r;
    hold_nxt = hold_r;
    lock_nxt = lock_r && !rel_s;
    lock_unit_nxt = lock_unit_r;
    start_nxt = 1'b0;
    req_nxt = 1'b0;
    we_nxt = 1'b0;
    maddr_nxt = maddr_r;
    mdata_nxt = mdata_r;
    stat_set = '0;
    stat_set[tcf_pkg::IND_EOT] = eot_rise;
    case (state_r)
      tcf_pkg::ST_IDLE: begin
        if (wr_fs) begin
          fs_nxt = i_bus_wdata[25:0];
          hard_nxt = 1'b0;
          erra_nxt = 1'b0;
          state_nxt = tcf_pkg::ST_CHECK;
        end
      end
      tcf_pkg::ST_CHECK: begin
        state_nxt = tcf_pkg::ST_IDLE;
        if (!u_dif.valid) begin
          stat_set[tcf_pkg::IND_FAULT] = 1'b1;
        end else if (u_dif.is_write && rd_chan) begin
          stat_set[tcf_pkg::IND_FAULT] = 1'b1;
        end else if (ufault_s || locked_here) begin
          stat_set[tcf_pkg::IND_FAULT] = 1'b1;
        end else if (ubusy_s || other_s) begin
          stat_set[tcf_pkg::IND_BUSY] = 1'b1;
        end else if (u_dif.is_lpt) begin
          if (lp_s) begin
            stat_set[tcf_pkg::IND_OK] = fs_int;
          end else begin
            stat_set[tcf_pkg::IND_HARD] = 1'b1;
            stat_set[tcf_pkg::IND_FAULT] = 1'b1;
          end
        end else begin
          start_nxt = 1'b1;
          hold_nxt = 1'b1;
          first_nxt = 1'b1;
          stop_nxt = 1'b0;
          pend_nxt = 1'b0;
          hard_nxt = 1'b0;
          erra_nxt = 1'b0;
          cnt_nxt = '0;
          addr_nxt = fs_addr;
          ptr_nxt = fs_addr;
          segment_descriptor_nxt = u_dif.is_scatter;
          back_nxt = u_dif.is_back;
          if (u_dif.is_rewind) begin
            cmd_nxt = u_dif.is_locked ? tcf_pkg::TC_REWIND_LOCKED :
              tcf_pkg::TC_REWIND;
            lock_nxt = u_dif.is_locked || lock_nxt;
            lock_unit_nxt = u_dif.is_locked ? unit : lock_unit_r;
            state_nxt = tcf_pkg::ST_FINISH;
          end else if (u_dif.is_recov) begin
            cmd_nxt = tcf_pkg::TC_SKIP_FWD;
            state_nxt = tcf_pkg::ST_SKIP;
          end else if (u_dif.is_write) begin
            cmd_nxt = tcf_pkg::TC_WRITE;
            state_nxt = tcf_pkg::ST_WAIT;
          end else begin
            cmd_nxt = u_dif.is_back ? tcf_pkg::TC_READ_BACK :
              tcf_pkg::TC_READ_FWD;
            state_nxt = u_dif.is_scatter ? tcf_pkg::ST_DESC :
              tcf_pkg::ST_XFER;
          end
        end
      end
      tcf_pkg::ST_SKIP: begin
        if (done_ev) begin
          start_nxt = 1'b1;
          cmd_nxt = tcf_pkg::TC_READ_FWD;
          state_nxt = segment_descriptor_r ? tcf_pkg::ST_DESC : tcf_pkg::ST_XFER;
        end
      end
      tcf_pkg::ST_DESC: begin
        if (!pend_r) begin
          req_nxt = 1'b1;
          maddr_nxt = ptr_r;
          pend_nxt = 1'b1;
        end else if (i_mem_valid) begin
          pend_nxt = 1'b0;
          ptr_nxt = ptr_r + step;
          first_nxt = 1'b0;
          stop_nxt = desc_stop;
          cnt_nxt = i_mem_rdata[tcf_pkg::DESC_CNT_LO +: tcf_pkg::CNT_W];
          addr_nxt = i_mem_rdata[tcf_pkg::FS_ADDR_LO +: tcf_pkg::ADDR_W];
          state_nxt = tcf_pkg::ST_XFER;
        end
        if (done_ev) begin
          erra_nxt = erra_r || bad_s;
          state_nxt = tcf_pkg::ST_FINISH;
        end
      end
      tcf_pkg::ST_XFER: begin
        if (word_ev) begin
          hard_nxt = hard_r || werr_s;
          if (xfer_on) begin
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            maddr_nxt = addr_r;
            mdata_nxt = word_s;
            addr_nxt = addr_r + step;
            cnt_nxt = segment_descriptor_r ? cnt_r - tcf_pkg::CNT_ONE : cnt_r;
          end
        end else if (segment_descriptor_r && !stop_r && cnt_r == '0) begin
          state_nxt = tcf_pkg::ST_DESC;
        end
        if (done_ev) begin
          erra_nxt = erra_r || bad_s;
          state_nxt = tcf_pkg::ST_FINISH;
        end
      end
      tcf_pkg::ST_WAIT: begin
        if (done_ev) begin
          hard_nxt = hard_r || werr_s;
          erra_nxt = erra_r || bad_s;
          state_nxt = tcf_pkg::ST_FINISH;
        end
      end
      tcf_pkg::ST_FINISH: begin
        state_nxt = tcf_pkg::ST_IDLE;
        hold_nxt = 1'b0;
        if (rd_chan) begin
          stat_set[tcf_pkg::IND_HARD] = hard_r;
          stat_set[tcf_pkg::IND_ERRA] = erra_r;
        end
        if (!pend_err) begin
          stat_set[tcf_pkg::IND_OK] = fs_int;
          req_nxt = 1'b1;
          maddr_nxt = tcf_pkg::STBY_ADDR;
        end
      end
      default: state_nxt = tcf_pkg::ST_IDLE;
    endcase
    if (!rd_chan && hold_r) begin
      stat_set[tcf_pkg::IND_HARD] = hard_nxt && !hard_r;
      stat_set[tcf_pkg::IND_ERRA] = erra_nxt && !erra_r;
    end
  end

  assign ctrl_nxt = wr_ctrl ? i_bus_wdata[tcf_pkg::CTRL_RDCH] : ctrl_r;
  assign stat_nxt = (stat_r & ~stat_clr) | stat_set;
  assign rdata_nxt = i_bus_rd ? rd_mux : '0;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= tcf_pkg::ST_IDLE;
      cmd_r <= tcf_pkg::TC_NONE;
      {fs_r, ctrl_r, stat_r, ptr_r, addr_r, cnt_r} <= '0;
      {segment_descriptor_r, back_r, first_r, stop_r, pend_r, hard_r, erra_r} <= '0;
      {lock_r, lock_unit_r, hold_r, start_r, req_r, we_r} <= '0;
      {maddr_r, mdata_r, rdata_r, wtgl_q, dtgl_q, eot_q} <= '0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      {fs_r, ctrl_r, stat_r, ptr_r, addr_r, cnt_r} <=
        {fs_nxt, ctrl_nxt, stat_nxt, ptr_nxt, addr_nxt, cnt_nxt};
      {segment_descriptor_r, back_r, first_r, stop_r, pend_r, hard_r, erra_r} <=
        {segment_descriptor_nxt, back_nxt, first_nxt, stop_nxt, pend_nxt, hard_nxt,
         erra_nxt};
      {lock_r, lock_unit_r, hold_r, start_r, req_r, we_r} <=
        {lock_nxt, lock_unit_nxt, hold_nxt, start_nxt, req_nxt, we_nxt};
      {maddr_r, mdata_r, rdata_r} <= {maddr_nxt, mdata_nxt, rdata_nxt};
      {wtgl_q, dtgl_q, eot_q} <= {wtgl_s, dtgl_s, eot_s};
    end
  end

  assign o_bus_rdata = rdata_r;
  assign o_mem_req = req_r;
  assign o_mem_we = we_r;
  assign o_mem_addr = maddr_r;
  assign o_mem_wdata = mdata_r;
  assign o_tape_start = start_r;
  assign o_tape_cmd = cmd_r;
  assign o_unit_sel = lock_unit_r;
  assign o_unit_hold = hold_r;
  assign o_unit_locked = lock_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  wire logic [7:0] ok_mask = (8'h01 << tcf_pkg::IND_OK) |
    (8'h01 << tcf_pkg::IND_EOT);
  wire logic [7:0] busy_bit = 8'h01 << tcf_pkg::IND_BUSY;
  wire logic [7:0] fault_bit = 8'h01 << tcf_pkg::IND_FAULT;
  wire logic [7:0] hard_bit = 8'h01 << tcf_pkg::IND_HARD;

  a_ok_alone: assert property (
    stat_set[tcf_pkg::IND_OK] |-> (stat_set & ~ok_mask) == '0)
    else $error("success set with another indicator");
  a_ok_needs_int: assert property (
    stat_set[tcf_pkg::IND_OK] |-> fs_int && !pend_err)
    else $error("success without interrupt or with error");
  a_lpt_busy_only: assert property (
    chk_lpt && !ufault_s && !locked_here && ubusy_s
    |-> (stat_set & ~ok_mask) == busy_bit ##1 !o_tape_start)
    else $error("busy load test did not set busy only");
  a_lpt_fault_only: assert property (
    chk_lpt && ufault_s |-> (stat_set & ~ok_mask) == fault_bit)
    else $error("faulted load test set other indicators");
  a_lpt_not_at: assert property (
    chk_lpt && move_ok && !lp_s
    |-> (stat_set & ~ok_mask) == (hard_bit | fault_bit))
    else $error("load test off point wrong indicators");
  a_bad_code: assert property (
    in_chk && !u_dif.valid
    |=> (stat_r & fault_bit) != '0 ##0 !o_tape_start [*2])
    else $error("unassigned code moved tape or no fault");
  a_no_stby_err: assert property (
    state_r == tcf_pkg::ST_FINISH && pend_err |=> !o_mem_req)
    else $error("standby access after failed specifier");
  a_skip_first: assert property (
    chk_go && u_dif.is_recov
    |=> o_tape_start && o_tape_cmd == tcf_pkg::TC_SKIP_FWD)
    else $error("recovery read did not skip first");
  a_rewind_cmd: assert property (
    chk_go && u_dif.is_rewind && !u_dif.is_locked
    |=> o_tape_cmd == tcf_pkg::TC_REWIND ##1 !o_unit_hold)
    else $error("free rewind sequence wrong");
  a_lock_holds: assert property (
    o_unit_locked && !rel_s |=> o_unit_locked)
    else $error("interlock dropped without release");
  a_rd_late: assert property (
    rd_chan && state_r != tcf_pkg::ST_FINISH
    |-> !stat_set[tcf_pkg::IND_HARD] || in_chk)
    else $error("read error posted before end");

  c_recov: cover property (chk_go && u_dif.is_recov ##[1:20] done_ev);
  c_lpt_ok: cover property (chk_lpt && stat_set[tcf_pkg::IND_OK]);
  c_stop_first: cover property (
    state_r == tcf_pkg::ST_DESC && pend_r && i_mem_valid && first_r &&
    desc_stop);
endmodule // tcf_channel
`default_nettype wire

// File: dv/tcf_far.sv
// Purpose: Memory and tape unit model for the channel bench
// Assumes: Memory answers a read one cycle after the request
// Notes:   Each read block carries three words
`default_nettype none
module tcf_far (
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [14:0] i_addr,
  input wire logic [25:0] i_wdata,
  output logic o_valid = 1'b0,
  output logic [25:0] o_rdata = 26'h0,
  input wire logic i_start,
  input wire logic [2:0] i_cmd,
  output logic [25:0] o_word = 26'h0,
  output logic o_word_tgl = 1'b0,
  output logic o_done_tgl = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] mem [0:32767];
  logic [2:0] cmds [0:15];
  int n_start = 0;
  int n_stby = 0;
  int wn = 0;
  initial begin
    foreach (mem[i]) mem[i] = 26'h0;
  end
  // Read data only in the answer cycle, scrambled otherwise
  always @(posedge i_clock) begin
    o_valid <= i_req && !i_we;
    o_rdata <= ~o_rdata;
    if (i_req && i_we) mem[i_addr] <= i_wdata;
    if (i_req && !i_we) begin
      o_rdata <= mem[i_addr];
      n_stby <= n_stby + int'(i_addr == 15'h0010);
    end
  end
  always @(posedge i_clock) begin
    if (i_start) begin
      cmds[n_start[3:0]] = i_cmd;
      n_start++;
      if (i_cmd inside {3'h1, 3'h2, 3'h3, 3'h6}) fork
        run(i_cmd);
      join_none
    end
  end
  // Words spaced ten cycles, held around each toggle
  task automatic run(input logic [2:0] c);
    repeat (10) @(posedge i_clock);
    if (c == 3'h2 || c == 3'h3) repeat (3) begin
      o_word <= 26'h1000000 | 26'(wn << 1);
      wn++;
      repeat (4) @(posedge i_clock);
      o_word_tgl <= ~o_word_tgl;
      repeat (6) @(posedge i_clock);
    end
    o_word <= ~o_word;
    o_done_tgl <= ~o_done_tgl;
  endtask
endmodule // tcf_far
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench for one tape channel
// Assumes: Status clear by writing ones, poll of state field
// Notes:   Pin inputs given five cycles to pass the syncs
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_bus_addr = 4'h0;
  logic [31:0] i_bus_wdata = 32'h0;
  logic i_bus_wr = 1'b0;
  logic i_bus_rd = 1'b0;
  logic [31:0] o_bus_rdata;
  logic o_mem_req, o_mem_we, i_mem_valid, wtgl, dtgl, o_tape_start;
  logic o_unit_hold, o_unit_locked;
  logic [14:0] o_mem_addr;
  logic [25:0] o_mem_wdata, i_mem_rdata, i_tape_word;
  logic [2:0] o_tape_cmd;
  logic [3:0] o_unit_sel;
  logic i_unit_busy = 1'b0, i_unit_fault = 1'b0, i_load_point = 1'b0;
  logic i_other_chan_busy = 1'b0, i_change_release = 1'b0;
  logic i_tape_word_err = 1'b0, i_tape_eot = 1'b0;
  logic [3:0] bad_f [3] = '{4'h9, 4'hb, 4'hd};
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  tcf_channel u_tcf_channel (.i_clock, .i_rst_b, .i_bus_addr, .i_bus_wdata,
    .i_bus_wr, .i_bus_rd, .o_bus_rdata, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .i_mem_valid, .i_mem_rdata, .i_tape_word,
    .i_tape_word_tgl(wtgl), .i_tape_word_err, .i_tape_bad_spot(1'b0),
    .i_tape_done_tgl(dtgl), .i_tape_eot, .i_unit_busy, .i_unit_fault,
    .i_load_point, .i_other_chan_busy, .i_change_release, .o_tape_start,
    .o_tape_cmd, .o_unit_sel, .o_unit_hold, .o_unit_locked);
  tcf_far u_tcf_far (.i_clock, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_valid(i_mem_valid),
    .o_rdata(i_mem_rdata), .i_start(o_tape_start), .i_cmd(o_tape_cmd),
    .o_word(i_tape_word), .o_word_tgl(wtgl), .o_done_tgl(dtgl));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_bus_addr <= a;
    i_bus_wdata <= d;
    i_bus_wr <= w;
    i_bus_rd <= !w;
    @(posedge i_clock);
    i_bus_wr <= 1'b0;
    i_bus_rd <= 1'b0;
    #1;
  endtask
  // Order busy, fault, load point, other channel, release
  task automatic pins(input logic [4:0] v);
    @(posedge i_clock);
    {i_unit_busy, i_unit_fault, i_load_point, i_other_chan_busy,
      i_change_release} <= v;
    repeat (5) @(posedge i_clock);
  endtask
  task automatic fs(input logic [3:0] u, input logic [3:0] f,
      input logic [14:0] a, input logic [7:0] st);
    int n;
    n = 0;
    bus(1'b1, 4'h4, 32'hfc);
    bus(1'b1, 4'h0, {7'h0, u, f, 1'b1, a, 1'b0});
    repeat (2) @(posedge i_clock);
    do begin
      bus(1'b0, 4'hc, 32'h0);
      n++;
    end while (o_bus_rdata[2:0] !== 3'h0 && n < 300);
    chk(o_bus_rdata[2:0], 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(o_bus_rdata, {24'h0, st});
  endtask
  function automatic logic [31:0] wv(input int k);
    return 32'(26'h1000000 | 26'(k << 1));
  endfunction
  task automatic t_lpt;
    int s;
    pins(5'h04);
    fs(4'h1, 4'hf, 15'h0, 8'h04);
    pins(5'h00);
    s = u_tcf_far.n_stby;
    fs(4'h1, 4'hf, 15'h0, 8'ha0);
    chk(u_tcf_far.n_stby, s);
    pins(5'h10);
    fs(4'h1, 4'hf, 15'h0, 8'h10);
    pins(5'h02);
    fs(4'h1, 4'hf, 15'h0, 8'h10);
    pins(5'h08);
    fs(4'h1, 4'hf, 15'h0, 8'h80);
    pins(5'h00);
    $display("load point test done");
  endtask
  task automatic t_bad;
    int s;
    s = u_tcf_far.n_start;
    foreach (bad_f[k]) fs(4'h1, bad_f[k], 15'h40, 8'h80);
    bus(1'b1, 4'h8, 32'h1);
    fs(4'h1, 4'h1, 15'h40, 8'h80);
    bus(1'b1, 4'h8, 32'h0);
    chk(u_tcf_far.n_start, s);
    $display("refused codes test done");
  endtask
  task automatic t_recov;
    int w, s, n;
    fs(4'h2, 4'he, 15'h100, 8'h04);
    w = u_tcf_far.wn;
    s = u_tcf_far.n_stby;
    n = u_tcf_far.n_start;
    fs(4'h2, 4'hc, 15'h100, 8'h04);
    chk(u_tcf_far.cmds[n[3:0]], 3'h1);
    chk(u_tcf_far.cmds[n[3:0] + 4'h1], 3'h2);
    for (int k = 0; k < 3; k++)
      chk(u_tcf_far.mem[15'h100 + k], wv(w + k));
    chk(u_tcf_far.n_stby, s + 1);
    chk(o_unit_hold, 1'b0);
    fs(4'h2, 4'he, 15'h100, 8'h04);
    u_tcf_far.mem[15'h200] = 26'((2 << 16) | (32'h300 << 1));
    u_tcf_far.mem[15'h201] = 26'h2000000;
    w = u_tcf_far.wn;
    fs(4'h2, 4'h8, 15'h200, 8'h04);
    chk(u_tcf_far.mem[15'h300], wv(w));
    chk(u_tcf_far.mem[15'h301], wv(w + 1));
    chk(u_tcf_far.mem[15'h302], 32'h0);
    w = u_tcf_far.wn;
    fs(4'h2, 4'h4, 15'h180, 8'h04);
    chk(u_tcf_far.mem[15'h180], wv(w));
    $display("recovery read test done");
  endtask
  task automatic t_err;
    int s;
    s = u_tcf_far.n_stby;
    bus(1'b1, 4'h8, 32'h1);
    @(posedge i_clock);
    i_tape_word_err <= 1'b1;
    fs(4'h6, 4'h4, 15'h240, 8'h20);
    chk(u_tcf_far.n_stby, s);
    @(posedge i_clock);
    i_tape_word_err <= 1'b0;
    bus(1'b1, 4'h8, 32'h0);
    u_tcf_far.mem[15'h260] = 26'h2000000;
    fs(4'h6, 4'h0, 15'h260, 8'h04);
    chk(u_tcf_far.mem[15'h0], 32'h0);
    @(posedge i_clock);
    i_tape_eot <= 1'b1;
    pins(5'h00);
    bus(1'b0, 4'h4, 32'h0);
    chk(o_bus_rdata, 32'h44);
    $display("error test done");
  endtask
  task automatic t_rew;
    int n;
    n = u_tcf_far.n_start;
    fs(4'h3, 4'h3, 15'h7ff, 8'h04);
    chk(u_tcf_far.cmds[n[3:0]], 3'h4);
    chk(o_unit_locked, 1'b0);
    fs(4'h5, 4'h7, 15'h123, 8'h04);
    chk(u_tcf_far.cmds[n[3:0] + 4'h1], 3'h5);
    chk({o_unit_locked, o_unit_sel}, 5'h15);
    pins(5'h01);
    chk(o_unit_locked, 1'b0);
    pins(5'h00);
    $display("rewind test done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_lpt();
    t_bad();
    t_recov();
    t_err();
    t_rew();
    finish_test();
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
endmodule // testbench
`default_nettype wire
